// >>> logic/sdsm_top.sv
// Card serial host: transfer modes, buffers, status and interrupt flags behind AHB-Lite.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Function
// - Eight transfer modes come from the alignment, sequential and unit receive bits.
// - With all mode bits zero the block only transmits written words.
// - Unit receive alone receives exactly one unit into the read register.
// - Without alignment, sequential receive keeps receiving whenever receive buffering has room.
// - Alignment with a receive mode runs full duplex aligned per unit.
// - Transmission continues while written transmit data remains and transmit is enabled.
// - Writing one to unit receive enable receives one unit; clear before reading.
// - Reading the read register in unit receive starts another unit.
// - Sequential receive double buffers so reads sustain back-to-back reception.
// - Without alignment both directions run independently; clock may run idle.
// - In aligned mode reception waits until transmit data exists.
// - Aligned units start on a transmit data write while transmit is enabled.
// - Four sources: read full, transmit buffer empty, shift full, shift empty.
// - Each status bit shows its buffer signal live.
// - Interrupt flags set on source rise, clear by write one when enabled.
// - An interrupt is raised only when its enable bit is one.
// - A request bit shows each live interrupt; clear-enable guards the flag.
// - The same flag structure exists for all four sources.
// - DMA enable bits route transmit empty or read full to DMA.
// - Status bits 3 to 0 are read-only and reset to 1,0,1,0.
// - With DMA enabled a source gives a one-shot pulse on its rise.
// - A unit is 8 or 16 bits by the word length select bit.
module sdsm_top
  import sdsm_pkg::*;
#(
  parameter int HALF = sdsm_pkg::HALF_DEFAULT
)
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output      logic              hreadyout,
  output      logic              hresp,
  output      logic [31:0]       hrdata,
  input  wire logic              miso,
  output      sdsm_pkg::sdsm_pins_s pins,
  output      logic              irq,
  output      logic              dma_tx_req,
  output      logic              dma_rx_req
);
  import sdsm_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  sdsm_regs_s s;
  sdsm_regs_s next_s;

  logic        seq;
  logic        urx;
  logic        aln;
  logic        wlen;
  logic        cen;
  logic        tx_go;
  logic        rx_want;
  logic        start;
  logic        sel;
  logic [11:0] idx;
  logic [3:0]  st;
  logic [3:0]  rise;
  logic [3:0]  dm;
  logic [3:0]  req;
  logic [31:0] rdata;

  // Mode decode: sequential receive overrides unit receive.
  assign seq  = s.ctrl[CT_SEQ_RX];
  assign urx  = s.ctrl[CT_UNIT_RX] & ~seq;
  assign aln  = s.ctrl[CT_ALIGN];
  assign wlen = s.ctrl[CT_WLEN];
  assign cen  = s.ctrl[CT_CEN];

  // Live status view of the four buffer signals.
  // Transmit counts as done only when neither the shift register nor the buffer holds data.
  // Polling software therefore never sees a false end between back-to-back units.
  assign st[ST_TX_DONE]  = ~(s.tx_sh_v | s.tx_buf_v);
  assign st[ST_RX_HOLD]  = s.rx_hold;
  assign st[ST_TX_EMPTY] = ~s.tx_buf_v;
  assign st[ST_RX_VALID] = s.rd_v;
  assign rise = st & ~s.st_prev;
  assign dm   = {2'h0, s.ctrl[CT_DMA_TX], s.ctrl[CT_DMA_RX]};
  assign req  = s.is & s.ie & ~dm;

  assign tx_go   = s.tx_buf_v & s.txen;
  assign rx_want = seq ? ~s.rx_hold : (urx & s.rx_armed);
  // Aligned units start only with transmit data; otherwise either side starts a unit.
  assign start   = cen & (aln ? tx_go : (tx_go | rx_want));

  assign sel = hsel & htrans[1] & hready;
  assign idx = (haddr[31:14] == 18'h0) ? haddr[13:2] : 12'h0;

  always_comb
  begin
    case (idx)
      IDX_CTRL: rdata = {16'h0, s.ctrl};
      IDX_STAT: rdata = {28'h0, st};
      IDX_IS:   rdata = {28'h0, s.is};
      IDX_WE:   rdata = {28'h0, s.we};
      IDX_IE:   rdata = {28'h0, s.ie};
      IDX_IR:   rdata = {28'h0, req};
      IDX_TD:   rdata = {16'h0, s.tx_buf};
      IDX_RD:   rdata = {16'h0, s.rd};
      IDX_TXEN: rdata = {31'h0, s.txen};
      default:  rdata = 32'h0;
    endcase
  end

  always_comb
  begin
    next_s        = s;
    next_s.dma_tx = 1'h0;
    next_s.dma_rx = 1'h0;
    next_s.miso1  = miso;
    next_s.miso2  = s.miso1;

    // Address phase: capture the access and prepare read data.
    next_s.ap_valid = sel;
    next_s.ap_write = hwrite;
    next_s.ap_idx   = idx;
    next_s.hrdata   = (sel & ~hwrite) ? rdata : 32'h0;
    if (sel & ~hwrite & (idx == IDX_RD))
    begin
      next_s.rd_v = 1'h0;
      if (urx)
      begin
        next_s.rx_armed = 1'h1;
      end
    end

    // Serial engine.
    case (s.state)
      SDSM_IDLE:
      begin
        if (s.rx_hold & ~s.rd_v)
        begin
          next_s.rd      = s.rx_sh;
          next_s.rd_v    = 1'h1;
          next_s.rx_hold = 1'h0;
        end
        if (start)
        begin
          next_s.state    = SDSM_SHIFT;
          next_s.bits     = wlen ? UNIT_BITS16 : UNIT_BITS8;
          next_s.tx_sh_v  = tx_go;
          next_s.tx_buf_v = 1'h0;
          if (tx_go)
          begin
            next_s.sh_out = wlen ? s.tx_buf : {s.tx_buf[7:0], 8'h00};
          end
          else
          begin
            next_s.sh_out = 16'hffff;
          end
          next_s.tx_buf_v = s.tx_buf_v & ~tx_go;
          next_s.rx_on    = rx_want;
          if (rx_want & urx)
          begin
            next_s.rx_armed = 1'h0;
          end
          next_s.div  = 8'h0;
          next_s.sclk = 1'h0;
        end
      end
      SDSM_SHIFT:
      begin
        next_s.div = s.div + 8'h1;
        if (s.div == HALF_LAST)
        begin
          next_s.div  = 8'h0;
          next_s.sclk = ~s.sclk;
          if (~s.sclk)
          begin
            next_s.rx_sh = {s.rx_sh[14:0], s.miso2};
          end
          else
          begin
            next_s.sh_out = {s.sh_out[14:0], 1'h1};
            next_s.bits   = s.bits - 5'h1;
            if (s.bits == 5'h1)
            begin
              next_s.state   = SDSM_IDLE;
              next_s.tx_sh_v = 1'h0;
              next_s.rx_on   = 1'h0;
              if (s.rx_on)
              begin
                next_s.rx_sh = wlen ? s.rx_sh : {8'h00, s.rx_sh[7:0]};
                if (~s.rd_v)
                begin
                  next_s.rd   = wlen ? s.rx_sh : {8'h00, s.rx_sh[7:0]};
                  next_s.rd_v = 1'h1;
                end
                else
                begin
                  next_s.rx_hold = 1'h1;
                end
              end
            end
          end
        end
      end
      default:
      begin
        next_s.state = SDSM_IDLE;
      end
    endcase

    // Data phase of a write.
    next_s.is = s.is;
    if (s.ap_valid & s.ap_write)
    begin
      case (s.ap_idx)
        IDX_CTRL:
        begin
          next_s.ctrl = hwdata[15:0] & CTRL_MASK;
          if (hwdata[CT_UNIT_RX] & ~s.ctrl[CT_UNIT_RX])
          begin
            next_s.rx_armed = 1'h1;
          end
        end
        IDX_IS:   next_s.is   = s.is & ~(hwdata[3:0] & s.we);
        IDX_WE:   next_s.we   = hwdata[3:0];
        IDX_IE:   next_s.ie   = hwdata[3:0];
        IDX_TXEN: next_s.txen = hwdata[0];
        IDX_TD:
        begin
          next_s.tx_buf   = hwdata[15:0];
          next_s.tx_buf_v = 1'h1;
        end
        default:  next_s.ctrl = s.ctrl;
      endcase
    end

    // Flags set on a rising source and win over a same-cycle clear.
    next_s.st_prev = st;
    next_s.is      = next_s.is | (rise & ~dm);
    next_s.dma_tx  = rise[ST_TX_EMPTY] & dm[ST_TX_EMPTY];
    next_s.dma_rx  = rise[ST_RX_VALID] & dm[ST_RX_VALID];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s          <= '0;
      s.state    <= SDSM_IDLE;
      s.ctrl     <= CTRL_RESET;
      s.txen     <= TXEN_RESET;
      s.st_prev  <= STAT_RESET;
      s.sh_out   <= 16'hffff;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hreadyout  = 1'h1;
  assign hresp      = 1'h0;
  assign hrdata     = s.hrdata;
  assign pins.sclk  = s.sclk;
  assign pins.mosi  = s.sh_out[15];
  assign pins.cs_n  = s.ctrl[CT_CS];
  assign pins.oe_n  = ~cen;
  assign irq        = |req;
  assign dma_tx_req = s.dma_tx;
  assign dma_rx_req = s.dma_rx;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence unit_start;
    (s.state == SDSM_IDLE) ##1 (s.state == SDSM_SHIFT);
  endsequence

  sequence unit_end;
    (s.state == SDSM_SHIFT) ##1 (s.state == SDSM_IDLE);
  endsequence

  a_mode_zero_tx: assert property ((s.ctrl[2:0] == 3'h0) && $past(s.ctrl[2:0] == 3'h0)
    ##0 $rose(s.state == SDSM_SHIFT) |-> !s.rx_on)
    else $error("Receive started with all mode bits clear.");

  a_tx_starts: assert property ((s.state == SDSM_IDLE) && tx_go && cen
    |=> (s.state == SDSM_SHIFT) && s.tx_sh_v)
    else $error("Pending transmit data did not start a unit.");

  a_seq_restart: assert property ((s.state == SDSM_IDLE) && seq && !aln && cen
    && !s.rx_hold |=> (s.state == SDSM_SHIFT) && s.rx_on)
    else $error("Sequential receive did not restart with free buffer.");

  a_align_wait: assert property ((s.state == SDSM_IDLE) && aln && !s.tx_buf_v
    |=> (s.state == SDSM_IDLE))
    else $error("Aligned unit started without transmit data.");

  a_unit_length: assert property (unit_start |-> (s.bits == (wlen ? UNIT_BITS16 : UNIT_BITS8)))
    else $error("Unit length does not match word length select.");

  a_rx_lands: assert property (s.rx_on && !s.rd_v ##0 unit_end |-> s.rd_v)
    else $error("Received unit not loaded into read register.");

  a_flag_sets: assert property ($rose(s.rd_v) && !s.ctrl[CT_DMA_RX] |=> s.is[ST_RX_VALID])
    else $error("Read-full flag missed the rising source.");

  a_irq_gate: assert property (irq |-> |(s.is & s.ie))
    else $error("Interrupt raised without an enabled flag.");

  a_dma_oneshot: assert property (dma_tx_req |=> !dma_tx_req)
    else $error("DMA request longer than one cycle.");

  a_stat_reset: assert property ($rose(rstn) |-> (st == STAT_RESET))
    else $error("Status does not show its reset value.");

  sequence rd_read;
    sel && !hwrite && (idx == IDX_RD);
  endsequence

  sequence hold_waiting;
    (s.state == SDSM_IDLE) && s.rx_hold && !s.rd_v;
  endsequence

  a_read_rearm: assert property (rd_read ##0 (urx && !s.rx_armed) |=> s.rx_armed)
    else $error("Read of the receive register did not arm another unit.");

  a_hold_moves: assert property (hold_waiting |=> s.rd_v && !s.rx_hold)
    else $error("Held unit did not move into the free read register.");

  a_seq_full_stop: assert property ((s.state == SDSM_IDLE) && seq && s.rx_hold && !tx_go
    |=> (s.state == SDSM_IDLE))
    else $error("Receive started with both receive buffers full.");

  a_td_fills: assert property (s.ap_valid && s.ap_write && (s.ap_idx == IDX_TD)
    |=> !st[ST_TX_EMPTY] && !st[ST_TX_DONE])
    else $error("Written transmit data not shown in the status.");

  a_dma_rx_pulse: assert property ($rose(s.rd_v) && s.ctrl[CT_DMA_RX] |=> dma_rx_req)
    else $error("Read-full source in DMA mode gave no request pulse.");

endmodule // sdsm_top

// >>> logic/sdsm_pkg.sv
// Constants, types and register map of the card serial mode and status block.
package sdsm_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [11:0] IDX_CTRL = 12'h822;
  localparam logic [11:0] IDX_STAT = 12'h824;
  localparam logic [11:0] IDX_IS   = 12'h828;
  localparam logic [11:0] IDX_WE   = 12'h82a;
  localparam logic [11:0] IDX_IE   = 12'h82c;
  localparam logic [11:0] IDX_IR   = 12'h82e;
  localparam logic [11:0] IDX_TD   = 12'h830;
  localparam logic [11:0] IDX_RD   = 12'h832;
  localparam logic [11:0] IDX_TXEN = 12'h834;

  // Field positions of serial_control_register.
  localparam int CT_UNIT_RX = 0;
  localparam int CT_SEQ_RX  = 1;
  localparam int CT_ALIGN   = 2;
  localparam int CT_WLEN    = 5;
  localparam int CT_CS      = 6;
  localparam int CT_CEN     = 7;
  localparam int CT_DMA_RX  = 8;
  localparam int CT_DMA_TX  = 9;
  localparam logic [15:0] CTRL_RESET = 16'h0040;
  localparam logic [15:0] CTRL_MASK  = 16'h03e7;

  // Field positions of serial_buffer_status.
  localparam int ST_RX_VALID = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_HOLD  = 2;
  localparam int ST_TX_DONE  = 3;
  localparam logic [3:0] STAT_RESET = 4'ha;
  localparam logic       TXEN_RESET = 1'h1;

  localparam logic [4:0] UNIT_BITS8  = 5'h08;
  localparam logic [4:0] UNIT_BITS16 = 5'h10;
  localparam int         HALF_DEFAULT = 4;

  typedef enum logic {SDSM_IDLE, SDSM_SHIFT} sdsm_state_e;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
    logic oe_n;
  } sdsm_pins_s;

  typedef struct packed {
    sdsm_state_e state;
    logic [15:0] ctrl;
    logic        txen;
    logic [3:0]  ie;
    logic [3:0]  we;
    logic [3:0]  is;
    logic [3:0]  st_prev;
    logic [15:0] tx_buf;
    logic        tx_buf_v;
    logic        tx_sh_v;
    logic [15:0] sh_out;
    logic [15:0] rx_sh;
    logic        rx_hold;
    logic        rx_on;
    logic        rx_armed;
    logic [15:0] rd;
    logic        rd_v;
    logic [4:0]  bits;
    logic [7:0]  div;
    logic        sclk;
    logic        miso1;
    logic        miso2;
    logic        ap_valid;
    logic        ap_write;
    logic [11:0] ap_idx;
    logic [31:0] hrdata;
    logic        dma_tx;
    logic        dma_rx;
  } sdsm_regs_s;

endpackage

// >>> verification/sdsm_card.sv
// Behavioural card model on the serial link of the card serial host.
`timescale 1ns/1ps
module sdsm_card #(
  parameter logic [15:0] WORD = 16'hc3a5
)
(
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  output      logic        miso,
  output      logic [15:0] rx_word,
  output      int          nbits
);
  logic [3:0] idx;
  // The data line has a pull-up, so it reads high whenever the card is not selected.
  assign miso = (cs_n | oe_n) ? 1'b1 : WORD[4'hf - idx];
  initial rx_word = 16'h0000;
  initial nbits = 0;
  always @(negedge sclk or posedge cs_n)
    if (cs_n)
      idx <= 4'h0;
    else
      idx <= idx + 4'h1;
  always @(posedge sclk)
    if (!cs_n)
    begin
      rx_word <= {rx_word[14:0], mosi};
      nbits   <= nbits + 1;
    end
endmodule // sdsm_card

// >>> verification/sdsm_top_tb.sv
// Self-checking bench of the card serial host with a card model on its link.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module sdsm_top_tb;
  import sdsm_pkg::*;
  localparam logic [15:0] WORD = 16'hc3a5;
  logic        clock, rstn, hsel, hwrite, hready, hreadyout, hresp, miso, irq;
  logic        dma_tx_req, dma_rx_req;
  logic [31:0] haddr, hwdata, hrdata, seed, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] card_rx;
  logic [7:0]  b1, b2;
  sdsm_pins_s  pins;
  int          card_bits, fails, n_checks, cyc, dma_cnt, nb0, dma_tx_cnt;

  assign hready = hreadyout;
  sdsm_top #(.HALF(4)) dut_u (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .miso(miso), .pins(pins),
    .irq(irq), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
  sdsm_card #(.WORD(WORD)) card_u (.sclk(pins.sclk), .mosi(pins.mosi), .cs_n(pins.cs_n),
    .oe_n(pins.oe_n), .miso(miso), .rx_word(card_rx), .nbits(card_bits));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic ahb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {18'h0, idx, 2'h0};
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, idx, d, x);
  endtask

  task automatic rdv(input logic [11:0] idx, output logic [31:0] v);
    ahb(1'b0, idx, 32'h0, v);
  endtask

  task automatic wait_bit(input int b);
    logic [31:0] s;
    for (int i = 0; i < 300; i++)
    begin
      rdv(IDX_STAT, s);
      if (s[b] === 1'b1)
        break;
    end
    `CHK(s[b], 1'b1)
  endtask

  // Chip select goes high with the modes off first, so the card restarts its word.
  task automatic set_mode(input logic [15:0] v);
    wr(IDX_CTRL, {16'h0, v & 16'hfff8} | 32'h40);
    wr(IDX_CTRL, {16'h0, v});
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (dma_rx_req === 1'b1)
      dma_cnt++;
    if (dma_tx_req === 1'b1)
      dma_tx_cnt++;
    if (cyc == 40000)
    begin
      fails++;
      close_out;
    end
  end

  initial
  begin
    rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; seed = 32'd71086;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1 `CHK({pins.cs_n, pins.oe_n, pins.sclk, pins.mosi, irq, hresp, hreadyout}, 7'h69)
    rdv(IDX_STAT, rv); `CHK(rv, {28'h0, STAT_RESET})
    wr(IDX_STAT, 32'h0); rdv(IDX_STAT, rv); `CHK(rv, {28'h0, STAT_RESET})
    rdv(IDX_CTRL, rv); `CHK(rv, {16'h0, CTRL_RESET})
    rdv(IDX_TXEN, rv); `CHK(rv, 32'h1)
    rdv(12'h826, rv); `CHK(rv, 32'h0)
    $display("test reset done");
    seed = xs(seed); b1 = seed[7:0]; seed = xs(seed); b2 = seed[15:8];
    set_mode(16'h0080); nb0 = card_bits;
    wr(IDX_TD, {24'h0, b1}); wr(IDX_TD, {24'h0, b2});
    rdv(IDX_STAT, rv); `CHK(rv[3:0], 4'h0)
    wait_bit(ST_TX_DONE); rdv(IDX_STAT, rv); `CHK(rv[3:0], 4'ha)
    `CHK(card_rx, {b1, b2})
    `CHK(card_bits - nb0, 16)
    rdv(IDX_IS, rv); `CHK(rv[3:0], 4'ha)
    `CHK(irq, 1'b0)
    wr(IDX_IE, 32'h2); `CHK(irq, 1'b1)
    rdv(IDX_IR, rv); `CHK(rv[1], 1'b1)
    wr(IDX_IS, 32'h2); rdv(IDX_IS, rv); `CHK(rv[1], 1'b1)
    wr(IDX_WE, 32'h2); wr(IDX_IS, 32'h2); rdv(IDX_IS, rv); `CHK(rv[1], 1'b0)
    `CHK(irq, 1'b0)
    wr(IDX_IE, 32'h0);
    $display("test transmit and flags done");
    set_mode(16'h00a1); nb0 = card_bits;
    wait_bit(ST_RX_VALID); rdv(IDX_RD, rv); `CHK(rv, {16'h0, WORD})
    wait_bit(ST_RX_VALID); wr(IDX_CTRL, 32'h00a0);
    rdv(IDX_RD, rv); `CHK(rv, {16'h0, WORD})
    rdv(IDX_STAT, rv); `CHK(rv[ST_RX_VALID], 1'b0)
    repeat (300) @(posedge clock);
    #1 `CHK(card_bits - nb0, 32)
    $display("test unit receive done");
    dma_cnt = 0;
    set_mode(16'h0183);
    for (int k = 0; k < 4; k++)
    begin
      wait_bit(ST_RX_VALID);
      rdv(IDX_RD, rv); `CHK(rv, {24'h0, k[0] ? WORD[7:0] : WORD[15:8]})
    end
    `CHK(dma_cnt > 3, 1'b1)
    wr(IDX_CTRL, 32'h0080);
    repeat (300) @(posedge clock);
    rdv(IDX_RD, rv); rdv(IDX_RD, rv);
    $display("test sequential receive done");
    seed = xs(seed); b1 = seed[7:0];
    wr(IDX_TXEN, 32'h0); set_mode(16'h0085); nb0 = card_bits;
    wr(IDX_TD, {24'h0, b1});
    repeat (200) @(posedge clock);
    #1 `CHK(card_bits, nb0)
    wr(IDX_TXEN, 32'h1); wait_bit(ST_RX_VALID);
    rdv(IDX_RD, rv); `CHK(rv, {24'h0, WORD[15:8]})
    `CHK(card_rx[7:0], b1)
    `CHK(card_bits - nb0, 8)
    $display("test aligned duplex done");
    seed = xs(seed); b2 = seed[23:16];
    set_mode(16'h0280); wr(IDX_WE, 32'hf); wr(IDX_IS, 32'hf); dma_tx_cnt = 0;
    wr(IDX_TD, {24'h0, b2}); wait_bit(ST_TX_DONE);
    `CHK(dma_tx_cnt, 1)
    `CHK(card_rx[7:0], b2)
    rdv(IDX_IS, rv); `CHK(rv[1], 1'b0)
    $display("test transmit DMA done");
    close_out;
  end
endmodule // sdsm_top_tb
